// File: rtl/lse_top.sv
// Local design decisions: the register offsets and the APB interface to the registers.
`include "lse_cfg.svh"
module lse_top import lse_pkg::*; #(
    parameter int unsigned MS_CYCLES = `LSE_MS_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // LED drive
    output logic [2:0]       led_pwm,
    output lse_rgb8_t        led_current,
    output logic             chip_active,
    output logic             cp_gain_1p5,
    // Shared trigger line, open drain
    input  wire logic        sync_line_in,
    output logic             sync_line_out,
    output logic             sync_line_oe,
    // Interrupt pin and general output
    output logic             irq_pin_out,
    output logic             irq_pin_oe,
    output logic             general_out_pin
);
    lse_top_st_t     s, n;
    logic            ms_tick;
    logic            wr, rd, stat_rd;
    logic [1:0]      bank;
    logic [2:0][7:0] duty_eff;
    logic [2:0]      run;
    lse_instr_t      ins0;
    logic [7:0]      ins0_pwm;
    logic [3:0]      ins0_tgt;

    assign wr      = psel & penable & pwrite;
    assign rd      = psel & penable & ~pwrite;
    assign stat_rd = rd && (paddr == `LSE_A_STATUS);
    assign bank    = paddr[7:6];

    lse_tick #(.MS_CYCLES(MS_CYCLES)) u_tick (
        .clk     (clk),
        .rst_n   (rst_n),
        .ms_tick (ms_tick)
    );

    always_comb begin
        logic [2:0][3:0] snd;
        logic [2:0][3:0] cons;
        logic [2:0]      endset;
        logic            done;
        logic            ext_edge;
        logic            mapped;
        logic [3:0]      nxt;
        logic [3:0]      p;
        logic [5:0]      cnt;
        logic [9:0]      sms;
        logic [31:0]     rv;
        lse_instr_t      ins;
        snd      = '0;
        cons     = '0;
        endset   = '0;
        done     = 1'b0;
        nxt      = '0;
        p        = '0;
        cnt      = '0;
        sms      = '0;
        rv       = '0;
        mapped   = 1'b1;
        ins      = '0;
        n        = s;
        // Ignore our own pulse so a send does not re-trigger this device
        ext_edge = s.sync_q & ~sync_line_in & (s.tpul == 4'h0);
        n.sync_q = sync_line_in;

        // Read data is captured in the setup phase, so no wait states are needed
        if (bank != 2'b00) begin
            rv = {8'h00, s.mem[bank - 2'b01][paddr[5:2]]};
        end else begin
            unique case (paddr)
                `LSE_A_ENABLE:  rv = {25'h000_0000, s.chip_en, s.ex};
                `LSE_A_OPMODE:  rv = {26'h000_0000, s.mode};
                `LSE_A_PWM:     rv = {8'h00, s.dpwm};
                `LSE_A_CURRENT: rv = {8'h00, s.cur};
                `LSE_A_CONFIG:  rv = {27'h000_0000, s.gout, s.gpo_lvl, s.gpo_en, s.cp};
                `LSE_A_STATUS:  rv = {4'h0, s.ch[2].pc, s.ch[1].pc, s.ch[0].pc,
                                      5'h00, run, 5'h00, s.endf};
                default:        mapped = 1'b0;
            endcase
        end
        if (psel && !penable) begin
            n.rdata  = mapped ? rv : 32'h0000_0000;
            n.slverr = ~mapped;
        end

        for (int c = 0; c < 3; c++) begin
            done = 1'b0;
            ins  = s.mem[c][s.ch[c].pc];
            nxt  = s.ch[c].pc + 4'h1;
            p    = s.ch[c].pc;
            cnt  = ins.arg[`LSE_F_LOOP];
            sms  = ins.arg[`LSE_F_STEP_MS];
            // Step time clamp bounds each step below 1000 ms
            if (sms == 10'h000) begin
                sms = 10'h001;
            end else if (sms > `LSE_WAIT_MAX_MS) begin
                sms = `LSE_WAIT_MAX_MS;
            end
            if (s.mode[c] == MODE_OFF) begin
                n.ch[c].pc   = '0;
                n.ch[c].st   = ST_FETCH;
                n.ch[c].lact = '0;
            end else if (run[c]) begin
                unique case (s.ch[c].st)
                    ST_FETCH: begin
                        unique case (ins.op)
                            OP_WAIT: begin
                                if (ins.arg[`LSE_F_MS] == 10'h000) begin
                                    done = 1'b1;
                                end else begin
                                    n.ch[c].st  = ST_WAIT;
                                    n.ch[c].tmr = (ins.arg[`LSE_F_MS] > `LSE_WAIT_MAX_MS) ?
                                                  `LSE_WAIT_MAX_MS : ins.arg[`LSE_F_MS];
                                end
                            end
                            OP_RAMP: begin
                                n.ch[c].st    = ST_RAMP;
                                n.ch[c].tmr   = sms;
                                n.ch[c].steps = {1'b0, ins.arg[`LSE_F_STEPS]} + 8'h01;
                            end
                            OP_BRANCH: begin
                                done = 1'b1;
                                if (cnt == 6'h00) begin
                                    nxt = ins.arg[`LSE_F_TARGET];
                                end else if (!s.ch[c].lact[p]) begin
                                    if (cnt != 6'h01) begin
                                        nxt             = ins.arg[`LSE_F_TARGET];
                                        n.ch[c].lact[p] = 1'b1;
                                        n.ch[c].lcnt[p] = cnt - 6'h02;
                                    end
                                end else if (s.ch[c].lcnt[p] != 6'h00) begin
                                    nxt             = ins.arg[`LSE_F_TARGET];
                                    n.ch[c].lcnt[p] = s.ch[c].lcnt[p] - 6'h01;
                                end else begin
                                    n.ch[c].lact[p] = 1'b0;
                                end
                            end
                            OP_SETPWM: begin
                                n.ch[c].duty = ins.arg[`LSE_F_PWM];
                                done         = 1'b1;
                            end
                            OP_START: begin
                                nxt  = 4'h0;
                                done = 1'b1;
                            end
                            OP_SYNC_LINE: begin
                                snd[c] = ins.arg[`LSE_F_SENDM];
                                if (ins.arg[`LSE_F_WAITM] == 4'h0) begin
                                    done = 1'b1;
                                end else begin
                                    n.ch[c].st    = ST_TRIGW;
                                    n.ch[c].wmask = ins.arg[`LSE_F_WAITM];
                                end
                            end
                            OP_END, OP_RSVD: begin
                                // Restarting after an end without reset re-runs the end at once
                                n.ex[c] = EX_HOLD;
                                if (ins.op == OP_END) begin
                                    endset[c] = ins.arg[`LSE_F_END_IRQ];
                                    if (ins.arg[`LSE_F_END_RST]) begin
                                        n.ch[c].pc = 4'h0;
                                    end
                                end
                            end
                        endcase
                    end
                    ST_WAIT: begin
                        if (ms_tick) begin
                            n.ch[c].tmr = s.ch[c].tmr - 10'h001;
                            done        = (s.ch[c].tmr == 10'h001);
                        end
                    end
                    ST_RAMP: begin
                        if (ms_tick) begin
                            n.ch[c].tmr = s.ch[c].tmr - 10'h001;
                            if (s.ch[c].tmr == 10'h001) begin
                                n.ch[c].tmr   = sms;
                                n.ch[c].steps = s.ch[c].steps - 8'h01;
                                done          = (s.ch[c].steps == 8'h01);
                                if (ins.arg[`LSE_F_DOWN]) begin
                                    if (s.ch[c].duty != 8'h00) begin
                                        n.ch[c].duty = s.ch[c].duty - 8'h01;
                                    end
                                end else if (s.ch[c].duty != 8'hFF) begin
                                    n.ch[c].duty = s.ch[c].duty + 8'h01;
                                end
                            end
                        end
                    end
                    ST_TRIGW: begin
                        if ((s.ch[c].tpend & s.ch[c].wmask) == s.ch[c].wmask) begin
                            cons[c] = s.ch[c].wmask;
                            done    = 1'b1;
                        end
                    end
                endcase
            end
            if (done) begin
                n.ch[c].pc = nxt;
                n.ch[c].st = ST_FETCH;
                if (s.ex[c] == EX_STEP) begin
                    n.ex[c] = EX_HOLD;
                end
            end
        end

        // Arriving triggers win over the consumption in the same cycle
        for (int c = 0; c < 3; c++) begin
            n.ch[c].tpend = (s.ch[c].tpend & ~cons[c]) |
                            {ext_edge, snd[2][c], snd[1][c], snd[0][c]};
        end
        if (snd[0][3] | snd[1][3] | snd[2][3]) begin
            n.tpul = `LSE_SYNC_LINE_PULSE;
        end else if (s.tpul != 4'h0) begin
            n.tpul = s.tpul - 4'h1;
        end
        // Clear only the flags the host saw at setup, so a flag raised during the read survives
        n.endf = (s.endf & ~(stat_rd ? s.rdata[2:0] : 3'b000)) | endset;

        // Software writes land last so they override hardware updates
        if (wr) begin
            if (bank != 2'b00) begin
                if (s.mode[bank - 2'b01] == MODE_LOAD) begin
                    n.mem[bank - 2'b01][paddr[5:2]] = pwdata[23:0];
                end
            end else begin
                unique case (paddr)
                    `LSE_A_ENABLE: begin
                        n.chip_en = pwdata[`LSE_EN_CHIP];
                        n.ex      = pwdata[5:0];
                    end
                    `LSE_A_OPMODE:  n.mode = pwdata[5:0];
                    `LSE_A_PWM:     n.dpwm = pwdata[23:0];
                    `LSE_A_CURRENT: n.cur  = pwdata[23:0];
                    `LSE_A_CONFIG: begin
                        n.cp      = pwdata[1:0];
                        n.gpo_en  = pwdata[`LSE_CFG_GPO_EN];
                        n.gpo_lvl = pwdata[`LSE_CFG_GPO_LVL];
                        n.gout    = pwdata[`LSE_CFG_GOUT];
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    for (genvar c = 0; c < 3; c++) begin : g_chan
        assign run[c] = s.chip_en && (s.mode[c] == MODE_RUN) && (s.ex[c] != EX_HOLD);
        assign duty_eff[c] = !s.chip_en ? 8'h00 :
                             (s.mode[c] == MODE_DIRECT) ? s.dpwm[c] :
                             (s.mode[c] != MODE_RUN) ? 8'h00 :
                             (s.ch[c].st == ST_TRIGW && s.ch[c].wmask[3]) ? 8'h00 :
                             s.ch[c].duty;
        lse_pwm u_pwm (
            .clk     (clk),
            .rst_n   (rst_n),
            .duty    (duty_eff[c]),
            .pwm_out (led_pwm[c])
        );
    end

    assign prdata          = s.rdata;
    assign pready          = 1'b1;
    assign pslverr         = s.slverr;
    assign led_current     = s.cur;
    assign chip_active     = s.chip_en;
    assign cp_gain_1p5     = s.cp[1];
    assign sync_line_out   = 1'b0;
    assign sync_line_oe    = (s.tpul != 4'h0);
    assign irq_pin_oe      = s.gpo_en | (|s.endf);
    assign irq_pin_out     = s.gpo_en & s.gpo_lvl;
    assign general_out_pin = s.gout;

    assign ins0     = s.mem[0][s.ch[0].pc];
    assign ins0_pwm = ins0.arg[`LSE_F_PWM];
    assign ins0_tgt = ins0.arg[`LSE_F_TARGET];

    property p_ramp_step;
        @(posedge clk) disable iff (!rst_n)
        (s.ch[0].st == ST_RAMP) |=> (8'(s.ch[0].duty - $past(s.ch[0].duty)) inside {8'h00, 8'h01, 8'hFF});
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("ramp moved duty by more than one");

    property p_wait_hold;
        @(posedge clk) disable iff (!rst_n)
        (s.ch[0].st == ST_WAIT && !ms_tick && s.mode[0] == MODE_RUN) |=> $stable(s.ch[0].tmr);
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("wait timer moved without tick");

    property p_branch_inf;
        @(posedge clk) disable iff (!rst_n)
        (run[0] && s.ch[0].st == ST_FETCH && ins0.op == OP_BRANCH && ins0.arg[`LSE_F_LOOP] == 6'h00)
        |=> (s.ch[0].pc == $past(ins0_tgt));
    endproperty
    a_branch_inf: assert property (p_branch_inf) else $error("endless branch missed target");

    property p_setpwm;
        @(posedge clk) disable iff (!rst_n)
        (run[0] && s.ch[0].st == ST_FETCH && ins0.op == OP_SETPWM) |=> (s.ch[0].duty == $past(ins0_pwm));
    endproperty
    a_setpwm: assert property (p_setpwm) else $error("set duty not loaded");

    property p_start;
        @(posedge clk) disable iff (!rst_n)
        (run[0] && s.ch[0].st == ST_FETCH && ins0.op == OP_START) |=> (s.ch[0].pc == 4'h0);
    endproperty
    a_start: assert property (p_start) else $error("restart did not clear counter");

    property p_sync_line_send;
        @(posedge clk) disable iff (!rst_n)
        (run[0] && s.ch[0].st == ST_FETCH && ins0.op == OP_SYNC_LINE && ins0.arg[3]) |=> sync_line_oe [*8];
    endproperty
    a_sync_line_send: assert property (p_sync_line_send) else $error("external trigger pulse too short");

    property p_end_irq;
        @(posedge clk) disable iff (!rst_n)
        (run[0] && s.ch[0].st == ST_FETCH && ins0.op == OP_END && ins0.arg[`LSE_F_END_IRQ] && !wr)
        |=> (s.endf[0] && s.ex[0] == EX_HOLD);
    endproperty
    a_end_irq: assert property (p_end_irq) else $error("end did not stop and flag");

    property p_irq_hold;
        @(posedge clk) disable iff (!rst_n)
        ((|s.endf) && !stat_rd) |=> (|s.endf);
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped before status read");

    property p_gpo;
        @(posedge clk) disable iff (!rst_n)
        s.gpo_en |-> (irq_pin_oe && irq_pin_out == s.gpo_lvl);
    endproperty
    a_gpo: assert property (p_gpo) else $error("interrupt pin not following level bit");

    property p_direct;
        @(posedge clk) disable iff (!rst_n)
        (s.chip_en && s.mode[0] == MODE_DIRECT) |-> (duty_eff[0] == s.dpwm[0]);
    endproperty
    a_direct: assert property (p_direct) else $error("direct duty not followed");

    property p_ext_dark;
        @(posedge clk) disable iff (!rst_n)
        (s.mode[0] == MODE_RUN && s.ch[0].st == ST_TRIGW && s.ch[0].wmask[3]) [*2] |-> !led_pwm[0];
    endproperty
    a_ext_dark: assert property (p_ext_dark) else $error("LED lit while waiting external");

    c_ramp:   cover property (@(posedge clk) disable iff (!rst_n) s.ch[0].st == ST_RAMP ##1 s.ch[0].st == ST_FETCH);
    c_loop:   cover property (@(posedge clk) disable iff (!rst_n) $fell(s.ch[0].lact[3]));
    c_irq:    cover property (@(posedge clk) disable iff (!rst_n) $rose(irq_pin_oe) && !s.gpo_en);
    c_trigw:  cover property (@(posedge clk) disable iff (!rst_n) $fell(s.ch[0].st == ST_TRIGW));
endmodule : lse_top

// File: rtl/lse_cfg.svh
`ifndef LSE_CFG_SVH
`define LSE_CFG_SVH

// Timing
`define LSE_CLK_NS      10
`define LSE_MS_NS       1_000_000
`define LSE_MS_CYCLES   (`LSE_MS_NS / `LSE_CLK_NS)
`define LSE_WAIT_MAX_MS 10'h03E7
`define LSE_SYNC_LINE_PULSE  4'h8

// Register byte addresses
`define LSE_A_ENABLE    8'h00
`define LSE_A_OPMODE    8'h04
`define LSE_A_PWM       8'h08
`define LSE_A_CURRENT   8'h0C
`define LSE_A_CONFIG    8'h10
`define LSE_A_STATUS    8'h14

// Register fields
`define LSE_EN_CHIP     6
`define LSE_CFG_GPO_EN  2
`define LSE_CFG_GPO_LVL 3
`define LSE_CFG_GOUT    4

// Instruction argument fields
`define LSE_F_MS        9:0
`define LSE_F_STEP_MS   17:8
`define LSE_F_DOWN      7
`define LSE_F_STEPS     6:0
`define LSE_F_LOOP      13:8
`define LSE_F_TARGET    3:0
`define LSE_F_PWM       7:0
`define LSE_F_WAITM     7:4
`define LSE_F_SENDM     3:0
`define LSE_F_END_IRQ   1
`define LSE_F_END_RST   0

`endif

// File: rtl/lse_pkg.sv
package lse_pkg;

    typedef enum logic [2:0] {OP_WAIT, OP_RAMP, OP_BRANCH, OP_SETPWM,
                              OP_START, OP_SYNC_LINE, OP_END, OP_RSVD} lse_op_t;
    typedef enum logic [1:0] {MODE_OFF, MODE_LOAD, MODE_RUN, MODE_DIRECT} lse_mode_t;
    typedef enum logic [1:0] {EX_HOLD, EX_STEP, EX_RUN, EX_RSVD} lse_exec_t;
    typedef enum logic [1:0] {ST_FETCH, ST_RAMP, ST_WAIT, ST_TRIGW} lse_st_t;

    typedef struct packed {
        lse_op_t     op;
        logic [20:0] arg;
    } lse_instr_t;

    typedef struct packed {
        logic [7:0] b;
        logic [7:0] g;
        logic [7:0] r;
    } lse_rgb8_t;

    typedef struct packed {
        lse_st_t         st;
        logic [3:0]      pc;
        logic [7:0]      duty;
        logic [9:0]      tmr;
        logic [7:0]      steps;
        logic [15:0][5:0] lcnt;
        logic [15:0]     lact;
        logic [3:0]      tpend;
        logic [3:0]      wmask;
    } lse_chan_t;

    typedef struct packed {
        logic                  chip_en;
        logic [2:0][1:0]       ex;
        logic [2:0][1:0]       mode;
        logic [2:0][7:0]       dpwm;
        lse_rgb8_t             cur;
        logic [1:0]            cp;
        logic                  gpo_en;
        logic                  gpo_lvl;
        logic                  gout;
        logic [2:0]            endf;
        lse_instr_t [2:0][15:0] mem;
        lse_chan_t [2:0]       ch;
        logic [3:0]            tpul;
        logic                  sync_q;
        logic [31:0]           rdata;
        logic                  slverr;
    } lse_top_st_t;

    typedef struct packed {
        logic [16:0] cnt;
        logic        tick;
    } lse_tick_st_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic       out;
    } lse_pwm_st_t;

endpackage : lse_pkg

// File: rtl/lse_tick.sv
`include "lse_cfg.svh"
module lse_tick import lse_pkg::*; #(
    parameter int unsigned MS_CYCLES = `LSE_MS_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Millisecond strobe
    output logic      ms_tick
);
    lse_tick_st_t s, n;

    always_comb begin
        n = s;
        n.tick = 1'b0;
        if (s.cnt == 17'(MS_CYCLES - 1)) begin
            n.cnt  = '0;
            n.tick = 1'b1;
        end else begin
            n.cnt = s.cnt + 17'h0_0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign ms_tick = s.tick;
endmodule : lse_tick

// File: rtl/lse_pwm.sv
module lse_pwm import lse_pkg::*; (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Duty in, pulse out
    input  wire logic [7:0] duty,
    output logic            pwm_out
);
    lse_pwm_st_t s, n;

    always_comb begin
        n = s;
        n.cnt = s.cnt + 8'h01;
        // Counter skips 255 so a duty of 255 gives a steady high
        if (s.cnt == 8'hFE) begin
            n.cnt = 8'h00;
        end
        n.out = (s.cnt < duty);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign pwm_out = s.out;
endmodule : lse_pwm

// File: bench/lse_peer.sv
module lse_peer (
    // Shared trigger wire
    input  wire logic dut_oe,
    input  wire logic fire,
    output logic      line,
    output int        dut_pulses
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up keeps the wire high, so either side pulls it low to send
    assign line = !(dut_oe || fire);
    initial dut_pulses = 0;
    always @(posedge dut_oe) dut_pulses <= dut_pulses + 1;
endmodule : lse_peer

// File: bench/testbench.sv
module testbench import lse_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, err, sync_line, irq_pin_out, irq_pin_oe, sync_line_oe;
    logic        general_out_pin, chip_active, cp_gain_1p5;
    logic [2:0]  led_pwm;
    lse_rgb8_t   led_current;
    int          failures = 0, n_tests = 0, cycles = 0, dut_pulses;
    always #5 clk = ~clk;
    lse_top #(.MS_CYCLES(20)) lse_top_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .led_pwm(led_pwm), .led_current(led_current), .chip_active(chip_active),
        .cp_gain_1p5(cp_gain_1p5), .sync_line_in(sync_line), .sync_line_out(), .sync_line_oe(sync_line_oe),
        .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe), .general_out_pin(general_out_pin));
    lse_peer lse_peer_inst (.dut_oe(sync_line_oe), .fire(fire), .line(sync_line), .dut_pulses(dut_pulses));
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
        n_tests++;
        if ((got & mask) !== (exp & mask)) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test;
        end
    end
    task automatic t_regs;
        apb(1'b0, 8'h14, 32'h0000_0000);
        check(rd, 32'h0000_0000, '1);
        apb(1'b1, 8'h0C, 32'h0033_2211);
        apb(1'b1, 8'h00, 32'h0000_0040);
        apb(1'b1, 8'h10, 32'h0000_0012);
        repeat (2) @(posedge clk);
        check(32'(led_current), 32'h0033_2211, '1);
        check({chip_active, cp_gain_1p5, general_out_pin}, 32'h0000_0007, '1);
        apb(1'b0, 8'h18, 32'h0000_0000);
        check(err, 32'h0000_0001, '1);
        $display("test regs done");
    endtask : t_regs
    task automatic t_prog;
        apb(1'b1, 8'h04, 32'h0000_0001);
        apb(1'b1, 8'h40, 32'h00A0_0080);
        apb(1'b1, 8'h44, 32'h00A0_0008);
        apb(1'b1, 8'h48, 32'h00C0_0002);
        apb(1'b1, 8'h04, 32'h0000_0002);
        apb(1'b1, 8'h00, 32'h0000_0042);
        repeat (40) @(posedge clk);
        check(irq_pin_oe, 32'h0000_0000, 32'h0000_0001);
        fire <= 1'b1;
        repeat (4) @(posedge clk);
        fire <= 1'b0;
        for (int i = 0; i < 200 && irq_pin_oe !== 1'b1; i++) @(posedge clk);
        check(dut_pulses, 32'h0000_0001, '1);
        apb(1'b0, 8'h14, 32'h0000_0000);
        check(rd, 32'h0002_0001, 32'h000F_0007);
        apb(1'b0, 8'h14, 32'h0000_0000);
        check(rd, 32'h0000_0000, 32'h0000_0007);
        @(posedge clk);
        check(irq_pin_oe, 32'h0000_0000, 32'h0000_0001);
        $display("test program done");
    endtask : t_prog
    task automatic count_hi(output logic [31:0] hi);
        hi = 32'h0000_0000;
        @(posedge clk);
        repeat (255) begin
            @(negedge clk);
            hi += led_pwm[0];
        end
    endtask : count_hi
    task automatic t_seq;
        logic [31:0] hi;
        apb(1'b1, 8'h04, 32'h0000_0000);
        apb(1'b1, 8'h04, 32'h0000_0001);
        apb(1'b1, 8'h40, 32'h0060_0010);
        apb(1'b1, 8'h44, 32'h0000_0002);
        apb(1'b1, 8'h48, 32'h0020_0103);
        apb(1'b1, 8'h4C, 32'h0040_0202);
        apb(1'b1, 8'h50, 32'h0040_0206);
        apb(1'b1, 8'h54, 32'h0040_0007);
        apb(1'b1, 8'h58, 32'h0080_0000);
        apb(1'b1, 8'h5C, 32'h00C0_0002);
        apb(1'b1, 8'h04, 32'h0000_0002);
        apb(1'b1, 8'h00, 32'h0000_0042);
        for (int i = 0; i < 1000 && irq_pin_oe !== 1'b1; i++) @(posedge clk);
        apb(1'b0, 8'h14, 32'h0000_0000);
        check(rd, 32'h0007_0001, 32'h000F_0007);
        count_hi(hi);
        check(hi, 32'h0000_0018, '1);
        apb(1'b1, 8'h08, 32'h0000_0040);
        apb(1'b1, 8'h04, 32'h0000_0003);
        count_hi(hi);
        check(hi, 32'h0000_0040, '1);
        $display("test sequence done");
    endtask : t_seq
    task automatic t_gpo;
        apb(1'b1, 8'h10, 32'h0000_000C);
        repeat (2) @(posedge clk);
        check({irq_pin_oe, irq_pin_out}, 32'h0000_0003, '1);
        $display("test gpo done");
    endtask : t_gpo
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_prog;
        t_seq;
        t_gpo;
        finish_test;
    end
endmodule : testbench
